// [cdpd_consts.vh]
// Constants for the clock divider and power-down control block
`ifndef CDPD_CONSTS_VH
`define CDPD_CONSTS_VH
`define CDPD_OFF_RATIO 4'h0
`define CDPD_OFF_STBY 4'h4
`define CDPD_OFF_MODE 4'h8
`define CDPD_OFF_STAT 4'hC
`define CDPD_RATIO_RST 16'h0222
`define CDPD_ACT_RST 9'h092
`define CDPD_STBY_RST 16'h4F00
`define CDPD_STBY_WMASK 16'h9F00
`define CDPD_STBY_ONE 16'h4000
`define CDPD_RATIO_WMASK 16'h0777
`define CDPD_CPU_LSB 8
`define CDPD_PER_LSB 4
`define CDPD_EXT_LSB 0
`define CDPD_SEL_BIT 15
`define CDPD_WAIT_MSB 12
`define CDPD_WAIT_LSB 8
`define CDPD_PLL_MULT 4'h8
`define CDPD_DIV_W 3
`define CDPD_WAIT_W 20
`endif

// [cdpd_top.v]
// Clock divider and power-down control with AXI4-Lite registers
// Summary of operation
// - PLL factor fixed at eight
// - Divide PLL by one, two, four or eight
// - Independent CPU, peripheral, external ratios
// - New ratios after bus cycle ends
// - Peripheral clock never faster than CPU
// - Peripherals use peripheral clock, except DMA
// - Sleep when standby select and all-stop enable are zero
// - Software standby when select is one
// - Standby resets serial units, others retain
// - All-clock-stop halts peripherals, resets sync serial
// - All-clock-stop exits on external or watchdog
// - After reset peripherals stopped except DMA
// - Standby bits 14/13 read one/zero
// - Five-bit standby wait field
// - Wait counted on peripheral clock ticks
// - Ratio codes eight, four, two, one
`include "cdpd_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module cdpd_top (
  input wire clk_i, // PLL output clock
  input wire rstn_i, // Async reset, active low
  input wire [3:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output wire s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write strobes
  input wire s_axi_wvalid, // Write data valid
  output wire s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [3:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output wire s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  input wire sleep_exec_i, // Sleep instruction pulse
  input wire bus_busy_i, // Bus cycle in progress
  input wire ext_irq_i, // External interrupt
  input wire wdt_irq_i, // Watchdog interrupt
  input wire all_stop_en_i, // All-module-clock-stop enabled
  output reg cpu_clk_en_o, // CPU clock tick
  output reg per_clk_en_o, // Peripheral clock tick
  output reg ext_clk_en_o, // External bus clock tick
  output reg cpu_halt_o, // CPU halted
  output reg osc_stop_o, // Oscillator halted
  output reg wdt_halt_o, // Watchdog unit halted
  output reg per_halt_o, // Peripherals halted
  output reg port_hold_o, // Ports held
  output reg async_serial_rst_o, // Asynchronous serial unit reset
  output reg sync_serial_rst_o, // Synchronous serial unit reset
  output reg per_stop_o, // Peripherals module-stopped
  output reg [3:0] pll_mult_o // PLL factor
);
  localparam ST_RUN = 4'h1;
  localparam ST_SLEEP = 4'h2;
  localparam ST_STBY = 4'h4;
  localparam ST_ALL = 4'h8;
  localparam [1:0] RESP_OK = 2'h0;
  localparam [1:0] RESP_ERR = 2'h2;

  reg [15:0] ratio_ff;
  reg [15:0] stby_ff;
  reg per_run_ff;
  reg [8:0] act_ff; // applied cpu/per/ext codes
  reg pend_ff;
  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [`CDPD_WAIT_W-1:0] wait_ff;
  reg waiting_ff;
  reg [2:0] div_ff;
  reg [3:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg aw_ok_ff;
  reg w_ok_ff;

  //////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data taken in either order
  assign s_axi_awready = !aw_ok_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_ok_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire do_wr = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
  wire wr_lo = wstrb_ff[0];
  wire wr_hi = wstrb_ff[1];
  // Full-address decode: stray offsets and the read-only status
  // register answer with an error instead of being dropped silently
  wire wr_map = awaddr_ff == `CDPD_OFF_RATIO ||
    awaddr_ff == `CDPD_OFF_STBY || awaddr_ff == `CDPD_OFF_MODE;

  function [15:0] merge;
    input [15:0] old;
    input [15:0] val;
    input lo;
    input hi;
    begin
      merge = {hi ? val[15:8] : old[15:8], lo ? val[7:0] : old[7:0]};
    end
  endfunction

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
      ratio_ff <= `CDPD_RATIO_RST;
      stby_ff <= `CDPD_STBY_RST;
      per_run_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? RESP_OK : RESP_ERR;
        case (awaddr_ff)
          `CDPD_OFF_RATIO: ratio_ff <= merge(ratio_ff,
            wdata_ff[15:0], wr_lo, wr_hi) & `CDPD_RATIO_WMASK;
          `CDPD_OFF_STBY: stby_ff <= (merge(stby_ff, wdata_ff[15:0],
            wr_lo, wr_hi) & `CDPD_STBY_WMASK) | `CDPD_STBY_ONE;
          `CDPD_OFF_MODE: if (wr_lo) per_run_ff <= wdata_ff[0];
          default: ;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // AXI4-Lite read, answered one cycle after the address is taken
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OK;
      case (s_axi_araddr)
        `CDPD_OFF_RATIO: s_axi_rdata <= {16'h0, ratio_ff};
        `CDPD_OFF_STBY: s_axi_rdata <= {16'h0, stby_ff};
        `CDPD_OFF_MODE: s_axi_rdata <= {31'h0, per_run_ff};
        `CDPD_OFF_STAT: s_axi_rdata <= {17'h0, waiting_ff,
          pend_ff, state_ff, act_ff};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_ERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Ratio application: wait for the bus cycle, then load at a divider
  // wrap so every domain switches within one slowest period
  wire [2:0] req_cpu = ratio_ff[`CDPD_CPU_LSB+:3];
  wire [2:0] req_per = ratio_ff[`CDPD_PER_LSB+:3];
  wire [2:0] req_ext = ratio_ff[`CDPD_EXT_LSB+:3];
  wire wr_ratio = do_wr && awaddr_ff == `CDPD_OFF_RATIO;
  wire div_wrap = div_ff == 3'h7;

  // Prohibited codes (top bit set) keep the slowest divide
  function [2:0] legal;
    input [2:0] c;
    begin
      legal = c[2] ? 3'h3 : c;
    end
  endfunction

  // Slower code means higher value; clamp periph/ext to CPU rate
  function [2:0] clamp;
    input [2:0] c;
    input [2:0] cpu;
    begin
      clamp = (legal(c) < cpu) ? cpu : legal(c);
    end
  endfunction

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_ff <= 1'b0;
      act_ff <= `CDPD_ACT_RST;
    end else begin
      if (wr_ratio)
        pend_ff <= 1'b1;
      else if (pend_ff && !bus_busy_i && div_wrap) begin
        pend_ff <= 1'b0;
        act_ff <= {legal(req_cpu), clamp(req_per, legal(req_cpu)),
          clamp(req_ext, legal(req_cpu))};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Divider: code 0 = undivided, 1 = 1/2, 2 = 1/4, 3 = 1/8
  // All rates line up at div 7, so a ratio swap there cannot glitch
  function tick;
    input [2:0] c;
    input [2:0] d;
    begin
      case (c)
        3'h0: tick = 1'b1;
        3'h1: tick = d[0];
        3'h2: tick = d[1:0] == 2'h3;
        default: tick = d == 3'h7;
      endcase
    end
  endfunction

  wire clocks_on = state_ff == ST_RUN || state_ff == ST_SLEEP ||
    state_ff == ST_ALL;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_ff <= 3'h0;
      cpu_clk_en_o <= 1'b0;
      per_clk_en_o <= 1'b0;
      ext_clk_en_o <= 1'b0;
      pll_mult_o <= `CDPD_PLL_MULT;
    end else begin
      div_ff <= div_ff + 3'h1;
      pll_mult_o <= `CDPD_PLL_MULT;
      cpu_clk_en_o <= tick(act_ff[8:6], div_ff) &&
        state_ff == ST_RUN;
      per_clk_en_o <= tick(act_ff[5:3], div_ff) &&
        (clocks_on || waiting_ff);
      ext_clk_en_o <= tick(act_ff[2:0], div_ff) && clocks_on;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Power-down modes
  wire [4:0] wsel = stby_ff[`CDPD_WAIT_MSB:`CDPD_WAIT_LSB];
  reg [`CDPD_WAIT_W-1:0] wait_len;

  always @* begin
    case (wsel)
      5'h05: wait_len = 20'h00040;
      5'h06: wait_len = 20'h00200;
      5'h07: wait_len = 20'h00400;
      5'h08: wait_len = 20'h00800;
      5'h09: wait_len = 20'h01000;
      5'h0A: wait_len = 20'h04000;
      5'h0B: wait_len = 20'h08000;
      5'h0C: wait_len = 20'h10000;
      5'h0D: wait_len = 20'h20000;
      5'h0E: wait_len = 20'h40000;
      5'h0F: wait_len = 20'h80000;
      default: wait_len = 20'h80000; // Reserved: longest, safest
    endcase
  end

  wire wake_any = ext_irq_i || wdt_irq_i;

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN:
        if (sleep_exec_i) begin
          if (stby_ff[`CDPD_SEL_BIT])
            nxt_state = ST_STBY;
          else if (all_stop_en_i)
            nxt_state = ST_ALL;
          else
            nxt_state = ST_SLEEP;
        end
      ST_SLEEP: if (wake_any) nxt_state = ST_RUN;
      ST_ALL: if (wake_any) nxt_state = ST_RUN;
      ST_STBY:
        if (waiting_ff && per_clk_en_o && wait_ff == 20'h1)
          nxt_state = ST_RUN;
      default: nxt_state = ST_RUN;
    endcase
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= ST_RUN;
      waiting_ff <= 1'b0;
      wait_ff <= 20'h0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_STBY && !waiting_ff && ext_irq_i) begin
        waiting_ff <= 1'b1;
        wait_ff <= wait_len;
      end else if (waiting_ff && per_clk_en_o) begin
        if (wait_ff == 20'h1)
          waiting_ff <= 1'b0;
        wait_ff <= wait_ff - 20'h1;
      end
    end
  end

  // Ratios are untouched in standby, so restart uses them as before
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cpu_halt_o <= 1'b0;
      osc_stop_o <= 1'b0;
      wdt_halt_o <= 1'b0;
      per_halt_o <= 1'b0;
      port_hold_o <= 1'b0;
      async_serial_rst_o <= 1'b0;
      sync_serial_rst_o <= 1'b0;
      per_stop_o <= 1'b1;
    end else begin
      cpu_halt_o <= nxt_state != ST_RUN;
      osc_stop_o <= nxt_state == ST_STBY && !waiting_ff;
      wdt_halt_o <= nxt_state == ST_STBY;
      per_halt_o <= nxt_state == ST_STBY || nxt_state == ST_ALL;
      port_hold_o <= nxt_state == ST_STBY || nxt_state == ST_ALL;
      async_serial_rst_o <= nxt_state == ST_STBY;
      sync_serial_rst_o <= nxt_state == ST_STBY ||
        nxt_state == ST_ALL;
      per_stop_o <= !per_run_ff;
    end
  end
endmodule // cdpd_top
`default_nettype wire

// [cdpd_chk.sv]
// Port checker for the clock divider and power-down block
`timescale 1ns/1ps
`default_nettype none
module cdpd_chk (
  input wire logic clk_i, // Clock
  input wire logic rstn_i, // Reset, active low
  input wire logic sleep_exec_i, // Sleep pulse
  input wire logic ext_irq_i, // External interrupt
  input wire logic wdt_irq_i, // Watchdog interrupt
  input wire logic cpu_halt_o, // CPU halted
  input wire logic osc_stop_o, // Oscillator halted
  input wire logic wdt_halt_o, // Watchdog halted
  input wire logic per_halt_o, // Peripherals halted
  input wire logic port_hold_o, // Ports held
  input wire logic async_serial_rst_o, // Async serial reset
  input wire logic sync_serial_rst_o, // Sync serial reset
  input wire logic per_stop_o, // Peripherals stopped
  input wire logic [3:0] pll_mult_o // PLL factor
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_pll_fixed: assert property (pll_mult_o == 4'h8)
    else $error("PLL factor is not eight");
  a_sleep_halts: assert property (sleep_exec_i && !cpu_halt_o |=>
    cpu_halt_o)
    else $error("CPU not halted after sleep");
  a_sleep_runs_rest: assert property (cpu_halt_o && !per_halt_o |->
    !osc_stop_o && !wdt_halt_o && !port_hold_o)
    else $error("Sleep stopped more than the CPU");
  a_standby_state: assert property (osc_stop_o |-> cpu_halt_o &&
    wdt_halt_o && async_serial_rst_o && sync_serial_rst_o)
    else $error("Standby outputs inconsistent");
  a_allstop_state: assert property (sync_serial_rst_o &&
    !async_serial_rst_o |-> per_halt_o && port_hold_o && !osc_stop_o)
    else $error("All-stop outputs inconsistent");
  a_stby_wdt_ignored: assert property (osc_stop_o && wdt_irq_i &&
    !ext_irq_i && !$past(ext_irq_i) |=> osc_stop_o)
    else $error("Watchdog left standby");
  a_stby_wait_hold: assert property (osc_stop_o && ext_irq_i |=>
    cpu_halt_o [*8])
    else $error("CPU resumed before settling wait");
  a_reset_stopped: assert property ($rose(rstn_i) |-> per_stop_o)
    else $error("Peripherals not stopped after reset");
endmodule // cdpd_chk
bind cdpd_top cdpd_chk u_chk (.*);
`default_nettype wire

// [cdpd_top_tb_top.sv]
// Register and power-mode testbench for the clock divider block
`timescale 1ns/1ps
`default_nettype none
module cdpd_top_tb_top;
  logic clk_i = 0, rstn_i = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic sleep_exec_i = 0, bus_busy_i = 0, ext_irq_i = 0, wdt_irq_i = 0;
  logic all_stop_en_i = 0, ra, rb;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'h3;
  logic [31:0] s_axi_wdata = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, cpu_clk_en_o, per_clk_en_o, ext_clk_en_o, cpu_halt_o;
  wire osc_stop_o, wdt_halt_o, per_halt_o, port_hold_o, per_stop_o;
  wire async_serial_rst_o, sync_serial_rst_o;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] pll_mult_o;
  integer n_mismatch = 0, n_checks = 0, t, nc, np, ne;
  always #2 clk_i = ~clk_i;
  cdpd_top uut (.*);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic sl(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  // Inputs sampled at the edge, before the design's updates land
  task automatic wr(input logic [3:0] a, input logic [15:0] d,
                    input logic [31:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    ra = 1'b1;
    rb = 1'b1;
    for (t = 0; t < 99 && (ra || rb); t++) begin
      @(posedge clk_i);
      ra = ra && !s_axi_awready;
      rb = rb && !s_axi_wready;
      s_axi_awvalid <= ra;
      s_axi_wvalid <= rb;
    end
    chk("aw w taken", {30'h0, ra, rb}, 32'h0);
    s_axi_bready <= 1'b1;
    for (t = 0; t < 99 && !rb; t++) begin
      @(posedge clk_i);
      rb = s_axi_bvalid;
    end
    s_axi_bready <= 1'b0;
    chk("bvalid", {31'h0, rb}, 32'h1);
    chk("bresp", {30'h0, s_axi_bresp}, er);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, m);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    ra = 1'b1;
    for (t = 0; t < 99 && ra; t++) begin
      @(posedge clk_i);
      ra = !s_axi_arready;
    end
    s_axi_arvalid <= 1'b0;
    chk("ar taken", {31'h0, ra}, 32'h0);
    s_axi_rready <= 1'b1;
    for (t = 0; t < 99 && !ra; t++) begin
      @(posedge clk_i);
      ra = s_axi_rvalid;
    end
    s_axi_rready <= 1'b0;
    chk("rvalid", {31'h0, ra}, 32'h1);
    chk("rresp", {30'h0, s_axi_rresp}, 32'h0);
    chk("rdata", s_axi_rdata & m, e);
  endtask
  task automatic go(input logic [2:0] k);
    {sleep_exec_i, ext_irq_i, wdt_irq_i} <= k;
    sl(1);
    {sleep_exec_i, ext_irq_i, wdt_irq_i} <= 3'h0;
  endtask
  task automatic wake;
    for (t = 0; t < 300 && cpu_halt_o; t++) sl(1);
    chk("cpu_halt", {31'h0, cpu_halt_o}, 32'h0);
  endtask
  // Window of 64 cycles is a multiple of every tick period
  task automatic cnt(input integer c, p, e);
    nc = 0;
    np = 0;
    ne = 0;
    repeat (64) begin
      @(posedge clk_i);
      nc += cpu_clk_en_o;
      np += per_clk_en_o;
      ne += ext_clk_en_o;
    end
    chk("cpu ticks", nc, c);
    chk("per ticks", np, p);
    chk("ext ticks", ne, e);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #80000;
    n_mismatch++;
    end_of_test;
  end
  initial begin
    sl(8);
    rstn_i <= 1'b1;
    sl(1);
    chk("pll", {28'h0, pll_mult_o}, 32'h8);
    chk("per_stop", {31'h0, per_stop_o}, 32'h1);
    rd(4'h0, 32'h0222, 32'hFFFF);
    rd(4'h4, 32'h4F00, 32'hFFFF);
    rd(4'hC, 32'h0292, 32'h7FFF);
    wr(4'h4, 16'hFFFF, 0);
    rd(4'h4, 32'hDF00, 32'hFFFF);
    wr(4'hC, 16'h0000, 2);
    wr(4'h8, 16'h0001, 0);
    sl(2);
    chk("per_stop", {31'h0, per_stop_o}, 32'h0);
    wr(4'h4, 16'h8500, 0);
    go(3'h4);
    sl(2);
    chk("stby", {cpu_halt_o, osc_stop_o, wdt_halt_o, async_serial_rst_o,
      sync_serial_rst_o}, 5'h1F);
    go(3'h1);
    sl(4);
    chk("stby wdt", {cpu_halt_o, osc_stop_o}, 2'h3);
    go(3'h2);
    sl(100);
    chk("stby wait", {31'h0, cpu_halt_o}, 32'h1);
    wake;
    wr(4'h4, 16'h4F00, 0);
    go(3'h4);
    sl(2);
    chk("sleep", {cpu_halt_o, osc_stop_o, wdt_halt_o, per_halt_o,
      port_hold_o}, 5'h10);
    rd(4'hC, 32'h0400, 32'h1E00);
    go(3'h1);
    wake;
    all_stop_en_i <= 1'b1;
    go(3'h4);
    sl(2);
    chk("all stop", {cpu_halt_o, osc_stop_o, per_halt_o, port_hold_o,
      async_serial_rst_o, sync_serial_rst_o}, 6'h2D);
    go(3'h1);
    wake;
    all_stop_en_i <= 1'b0;
    bus_busy_i <= 1'b1;
    wr(4'h0, 16'h0123, 0);
    sl(20);
    rd(4'hC, 32'h2000, 32'h2000);
    bus_busy_i <= 1'b0;
    sl(12);
    rd(4'hC, 32'h0053, 32'h21FF);
    cnt(32, 16, 8);
    wr(4'h0, 16'h0214, 0);
    sl(12);
    cnt(16, 16, 8);
    end_of_test;
  end
endmodule // cdpd_top_tb_top
`default_nettype wire
